// ### psm_host.sv
// Partner model: host on the serial configuration port
`timescale 1ns/10ps
`default_nettype none

module psm_host
(
    input  wire logic clk,
    input  wire logic cfg_sdout,
    output var  logic cfg_sel_n,
    output var  logic cfg_sclk,
    output var  logic cfg_sdin
);
    logic idle;

    initial
    begin
        idle = 1'b1;
        cfg_sel_n = 1'b1;
        cfg_sclk = 1'b0;
        cfg_sdin = 1'b0;
    end

    // Data line toggles while no frame runs
    always @(posedge clk) if (idle) cfg_sdin <= ~cfg_sdin;

    // One 24-bit frame, MSB first, 8 clk per serial clock phase
    task automatic xfer(input logic [23:0] f, output logic [7:0] q);
        #1 idle = 1'b0;
        @(posedge clk) cfg_sel_n <= 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            cfg_sdin <= f[i];
            repeat (8) @(posedge clk);
            cfg_sclk <= 1'b1;
            if (i < 8) q[i] = cfg_sdout;
            repeat (8) @(posedge clk);
            cfg_sclk <= 1'b0;
        end
        repeat (10) @(posedge clk);
        cfg_sel_n <= 1'b1;
        #1 idle = 1'b1;
        repeat (6) @(posedge clk);
    endtask : xfer
endmodule : psm_host

`default_nettype wire

// ### psm_page_sleep.sv
// Top: serial configuration port, page select and sleep-mask registers
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Page register: 80h master, 0Fh converter page
// - Digital pages use bank flag, not page
// - Two masks kept, applied by 55h bit
// - Mask choice from 26h bit 5
// - First mask lives at 20h and 21h
// - Second mask lives at 23h and 24h
// - Converter sleep nibbles, pairs AB and CD
// - Buffer sleep fields, pair AB bits 5-4, pair CD bits 7-6
// - Mask registers reachable only on master page
// - 26h: request, pin ignore, choice; rest zero
// - Chip sleep request needs pin ignore set first
// - Pin ignored while pin-ignore bit set
// - Choice 0 first mask, 1 second mask
// - Apply bit powers down selected mask blocks

module psm_page_sleep
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       cfg_sel_n,
    input  wire logic       cfg_sclk,
    input  wire logic       cfg_sdin,
    input  wire logic       sleep_pin,
    output var  logic       cfg_sdout,
    output var  logic       cfg_sdout_oe,
    output var  logic [3:0] converter_sleep_first_pair,
    output var  logic [3:0] converter_sleep_second_pair,
    output var  logic [1:0] input_buffer_sleep_first_pair,
    output var  logic [1:0] input_buffer_sleep_second_pair,
    output var  logic       chip_sleep,
    output var  logic       converter_page_selected
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic sel_n_s;
    logic sclk_s;
    logic sdin_s;
    logic pin_s;

    psm_sync #(.INIT(1'b1)) u_sync_sel   (.clk(clk), .sys_rst(sys_rst),
                                          .pin_in(cfg_sel_n), .pin_out(sel_n_s));
    psm_sync #(.INIT(1'b0)) u_sync_sclk  (.clk(clk), .sys_rst(sys_rst),
                                          .pin_in(cfg_sclk), .pin_out(sclk_s));
    psm_sync #(.INIT(1'b0)) u_sync_sdin  (.clk(clk), .sys_rst(sys_rst),
                                          .pin_in(cfg_sdin), .pin_out(sdin_s));
    psm_sync #(.INIT(1'b0)) u_sync_sleep (.clk(clk), .sys_rst(sys_rst),
                                          .pin_in(sleep_pin), .pin_out(pin_s));

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic sclk_d_reg;
    wire  sclk_rise = sclk_s & ~sclk_d_reg;
    wire  sclk_fall = ~sclk_s & sclk_d_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            sclk_d_reg <= 1'b0;
        else
            sclk_d_reg <= sclk_s;
    end

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    psm_pkg::psm_state_type       state_reg;
    logic [psm_pkg::CNT_W-1:0]    count_reg;
    logic [psm_pkg::FRAME_BITS-2:0] shift_reg;
    logic [psm_pkg::DATA_W-1:0]   rd_shift_reg;
    logic                         reading_reg;

    wire [psm_pkg::FRAME_BITS-1:0] full_frame = {shift_reg, sdin_s};
    wire [psm_pkg::HEADER_BITS-1:0] hdr = {shift_reg[psm_pkg::HEADER_BITS-2:0], sdin_s};
    wire bit_take   = (state_reg == psm_pkg::PSM_SHIFT) & sclk_rise;
    wire hdr_done   = bit_take & (count_reg == psm_pkg::HDR_LAST_CNT);
    wire frame_done = bit_take & (count_reg == psm_pkg::FRAME_LAST_CNT);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] page_reg;
    logic [7:0] m1_conv_reg;
    logic [7:0] m1_buf_reg;
    logic [7:0] m2_conv_reg;
    logic [7:0] m2_buf_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] apply_reg;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire        hdr_bank = hdr[psm_pkg::BANK_BIT - psm_pkg::DATA_W];
    wire [13:0] hdr_addr = hdr[psm_pkg::ADDR_W-1:0];
    wire        hdr_rd   = hdr[psm_pkg::RD_BIT - psm_pkg::DATA_W];
    wire        on_master = (page_reg == psm_pkg::PAGE_MASTER);

    wire        wr_bank  = full_frame[psm_pkg::BANK_BIT];
    wire        wr_rd    = full_frame[psm_pkg::RD_BIT];
    wire [13:0] wr_addr  = full_frame[psm_pkg::DATA_W +: psm_pkg::ADDR_W];
    wire [7:0]  wr_data  = full_frame[psm_pkg::DATA_W-1:0];
    wire        wr_go    = frame_done & ~wr_rd & ~wr_bank;
    wire        wr_mst   = wr_go & on_master;

    wire wr_page  = wr_go & (wr_addr == psm_pkg::ADDR_PAGE_SELECT);
    wire wr_m1c   = wr_mst & (wr_addr == psm_pkg::ADDR_M1_CONV);
    wire wr_m1b   = wr_mst & (wr_addr == psm_pkg::ADDR_M1_BUF);
    wire wr_m2c   = wr_mst & (wr_addr == psm_pkg::ADDR_M2_CONV);
    wire wr_m2b   = wr_mst & (wr_addr == psm_pkg::ADDR_M2_BUF);
    wire wr_ctrl  = wr_mst & (wr_addr == psm_pkg::ADDR_GLOBAL_CTRL);
    wire wr_apply = wr_mst & (wr_addr == psm_pkg::ADDR_GROUP_APPLY);
    wire soft_rst = wr_go & (wr_addr == psm_pkg::ADDR_SOFT_RESET)
                  & wr_data[psm_pkg::SWRST_HI_BIT] & wr_data[psm_pkg::SWRST_LO_BIT];

    // Chip sleep request accepted only once pin ignore is already set
    wire [7:0] ctrl_next = (wr_data & psm_pkg::CTRL_MASK &
                            ~(8'h80 & {8{~ctrl_reg[psm_pkg::IGNORE_PIN_BIT]}}));

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire rd_local = ~hdr_bank;
    wire rd_mst   = rd_local & on_master;
    wire [7:0] rd_mux =
        (rd_local & hdr_addr == psm_pkg::ADDR_PAGE_SELECT) ? page_reg    :
        (rd_mst   & hdr_addr == psm_pkg::ADDR_M1_CONV)     ? m1_conv_reg :
        (rd_mst   & hdr_addr == psm_pkg::ADDR_M1_BUF)      ? m1_buf_reg  :
        (rd_mst   & hdr_addr == psm_pkg::ADDR_M2_CONV)     ? m2_conv_reg :
        (rd_mst   & hdr_addr == psm_pkg::ADDR_M2_BUF)      ? m2_buf_reg  :
        (rd_mst   & hdr_addr == psm_pkg::ADDR_GLOBAL_CTRL) ? ctrl_reg    :
        (rd_mst   & hdr_addr == psm_pkg::ADDR_GROUP_APPLY) ? apply_reg   :
                                                             psm_pkg::RESET_VALUE;

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst | sel_n_s)
        begin
            state_reg   <= psm_pkg::PSM_IDLE;
            count_reg   <= '0;
            shift_reg   <= '0;
            reading_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                psm_pkg::PSM_IDLE:
                begin
                    state_reg <= psm_pkg::PSM_SHIFT;
                    count_reg <= '0;
                end
                psm_pkg::PSM_SHIFT:
                begin
                    if (sclk_rise)
                    begin
                        shift_reg <= full_frame[psm_pkg::FRAME_BITS-2:0];
                        count_reg <= count_reg + 5'h01;
                    end
                    if (hdr_done)
                        reading_reg <= hdr_rd;
                    if (frame_done)
                        state_reg <= psm_pkg::PSM_DONE;
                end
                psm_pkg::PSM_DONE:
                    state_reg <= psm_pkg::PSM_DONE;
                default:
                    state_reg <= psm_pkg::PSM_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data out, launched on falling edges
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst | sel_n_s)
        begin
            rd_shift_reg <= '0;
            cfg_sdout    <= 1'b0;
            cfg_sdout_oe <= 1'b0;
        end
        else if (hdr_done)
        begin
            rd_shift_reg <= rd_mux;
            cfg_sdout_oe <= hdr_rd;
        end
        else if (sclk_fall & reading_reg & (state_reg == psm_pkg::PSM_SHIFT))
        begin
            cfg_sdout    <= rd_shift_reg[psm_pkg::DATA_W-1];
            rd_shift_reg <= {rd_shift_reg[psm_pkg::DATA_W-2:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    wire reg_clear = sys_rst | soft_rst;

    always_ff @(posedge clk)
    begin
        if (reg_clear)
            page_reg <= psm_pkg::RESET_VALUE;
        else if (wr_page)
            page_reg <= wr_data;
    end

    always_ff @(posedge clk)
    begin
        if (reg_clear)
            m1_conv_reg <= psm_pkg::RESET_VALUE;
        else if (wr_m1c)
            m1_conv_reg <= wr_data & psm_pkg::CONV_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (reg_clear)
            m1_buf_reg <= psm_pkg::RESET_VALUE;
        else if (wr_m1b)
            m1_buf_reg <= wr_data & psm_pkg::BUF_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (reg_clear)
            m2_conv_reg <= psm_pkg::RESET_VALUE;
        else if (wr_m2c)
            m2_conv_reg <= wr_data & psm_pkg::CONV_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (reg_clear)
            m2_buf_reg <= psm_pkg::RESET_VALUE;
        else if (wr_m2b)
            m2_buf_reg <= wr_data & psm_pkg::BUF_MASK;
    end

    always_ff @(posedge clk)
    begin
        if (reg_clear)
            ctrl_reg <= psm_pkg::RESET_VALUE;
        else if (wr_ctrl)
            ctrl_reg <= ctrl_next;
    end

    always_ff @(posedge clk)
    begin
        if (reg_clear)
            apply_reg <= psm_pkg::RESET_VALUE;
        else if (wr_apply)
            apply_reg <= wr_data & psm_pkg::APPLY_MASK;
    end

    // ------------------------------------------------------------
    // Sleep outputs
    // ------------------------------------------------------------
    wire       choice  = ctrl_reg[psm_pkg::GROUP_SEL_BIT];
    wire       apply   = apply_reg[psm_pkg::GROUP_APPLY_BIT];
    wire [7:0] sel_cnv = choice ? m2_conv_reg : m1_conv_reg;
    wire [7:0] sel_buf = choice ? m2_buf_reg  : m1_buf_reg;
    wire       ignore  = ctrl_reg[psm_pkg::IGNORE_PIN_BIT];
    wire       sleep_now = ignore ? ctrl_reg[psm_pkg::SLEEP_REQ_BIT] : pin_s;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            converter_sleep_first_pair     <= '0;
            converter_sleep_second_pair    <= '0;
            input_buffer_sleep_first_pair  <= '0;
            input_buffer_sleep_second_pair <= '0;
        end
        else
        begin
            converter_sleep_first_pair     <= apply ? sel_cnv[7:4] : 4'h0;
            converter_sleep_second_pair    <= apply ? sel_cnv[3:0] : 4'h0;
            input_buffer_sleep_first_pair  <= apply ? sel_buf[5:4] : 2'h0;
            input_buffer_sleep_second_pair <= apply ? sel_buf[7:6] : 2'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            chip_sleep              <= 1'b0;
            converter_page_selected <= 1'b0;
        end
        else
        begin
            chip_sleep              <= sleep_now;
            converter_page_selected <= (page_reg == psm_pkg::PAGE_CONVERTER);
        end
    end

endmodule : psm_page_sleep

`default_nettype wire

// ### psm_page_sleep_chk.sv
// Checker: port-level assertions for the page and sleep-mask block
`timescale 1ns/10ps
`default_nettype none

module psm_page_sleep_chk
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       cfg_sel_n,
    input wire logic       cfg_sclk,
    input wire logic       cfg_sdin,
    input wire logic       sleep_pin,
    input wire logic       cfg_sdout,
    input wire logic       cfg_sdout_oe,
    input wire logic [3:0] converter_sleep_first_pair,
    input wire logic [3:0] converter_sleep_second_pair,
    input wire logic [1:0] input_buffer_sleep_first_pair,
    input wire logic [1:0] input_buffer_sleep_second_pair,
    input wire logic       chip_sleep,
    input wire logic       converter_page_selected
);
    logic [3:0]  quiet_reg;
    logic [3:0]  pin_age_reg;
    logic        pin_d_reg;
    logic [11:0] mask_bus;

    assign mask_bus = {converter_sleep_first_pair, converter_sleep_second_pair,
                       input_buffer_sleep_second_pair, input_buffer_sleep_first_pair};

    // Cycles since last frame activity and since last pin change
    always_ff @(posedge clk)
    begin
        pin_d_reg <= sleep_pin;
        if (sys_rst || !cfg_sel_n) quiet_reg <= 4'h0;
        else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
        if (sys_rst || sleep_pin != pin_d_reg) pin_age_reg <= 4'h0;
        else if (pin_age_reg != 4'hF) pin_age_reg <= pin_age_reg + 4'h1;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_RESET_CLEAR: assert property ($fell(sys_rst) |-> mask_bus == 12'h000
        && !chip_sleep && !converter_page_selected && !cfg_sdout_oe) else $error("outputs not clear");
    AST_MASK_HOLD: assert property (quiet_reg >= 4'h8 |-> $stable(mask_bus))
        else $error("mask outputs moved without a frame");
    AST_PAGE_HOLD: assert property (quiet_reg >= 4'h8 |-> $stable(converter_page_selected))
        else $error("page flag moved without a frame");
    AST_PIN_SETTLED: assert property (quiet_reg >= 4'h8 && pin_age_reg >= 4'h8
        |-> $stable(chip_sleep)) else $error("chip sleep moved with no cause");
    AST_PAGE_LOCK: assert property (converter_page_selected [*3] |-> $stable(mask_bus))
        else $error("mask changed off the master page");
    AST_OE_FRAME: assert property (cfg_sdout_oe |-> quiet_reg < 4'h8)
        else $error("read driver on outside a frame");
    AST_SDOUT_REST: assert property (!cfg_sdout_oe |-> !cfg_sdout)
        else $error("read data not at rest");
    AST_SDOUT_EDGE: assert property (cfg_sdout_oe && $changed(cfg_sdout) |-> !cfg_sclk)
        else $error("read data changed while serial clock high");

    cover property (cfg_sdout_oe);
    cover property ($rose(chip_sleep));
    cover property (mask_bus != 12'h000);
    cover property (converter_page_selected);
endmodule : psm_page_sleep_chk

bind psm_page_sleep psm_page_sleep_chk u_chk
(
    .clk(clk), .sys_rst(sys_rst), .cfg_sel_n(cfg_sel_n), .cfg_sclk(cfg_sclk),
    .cfg_sdin(cfg_sdin), .sleep_pin(sleep_pin), .cfg_sdout(cfg_sdout),
    .cfg_sdout_oe(cfg_sdout_oe), .converter_sleep_first_pair(converter_sleep_first_pair),
    .converter_sleep_second_pair(converter_sleep_second_pair),
    .input_buffer_sleep_first_pair(input_buffer_sleep_first_pair),
    .input_buffer_sleep_second_pair(input_buffer_sleep_second_pair),
    .chip_sleep(chip_sleep), .converter_page_selected(converter_page_selected)
);

`default_nettype wire

// ### psm_pkg.sv
// Package: register map, field positions, reset values and serial frame layout
package psm_pkg;

    // ------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------
    localparam int          FRAME_BITS     = 24;
    localparam int          HEADER_BITS    = 16;
    localparam int          ADDR_W         = 14;
    localparam int          DATA_W         = 8;
    localparam int          CNT_W          = 5;
    localparam int          RD_BIT         = 23;
    localparam int          BANK_BIT       = 22;
    localparam logic [4:0]  HDR_LAST_CNT   = 5'h0F;
    localparam logic [4:0]  FRAME_LAST_CNT = 5'h17;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [13:0] ADDR_SOFT_RESET  = 14'h0000;
    localparam logic [13:0] ADDR_PAGE_SELECT = 14'h0011;
    localparam logic [13:0] ADDR_M1_CONV     = 14'h0020;
    localparam logic [13:0] ADDR_M1_BUF      = 14'h0021;
    localparam logic [13:0] ADDR_M2_CONV     = 14'h0023;
    localparam logic [13:0] ADDR_M2_BUF      = 14'h0024;
    localparam logic [13:0] ADDR_GLOBAL_CTRL = 14'h0026;
    localparam logic [13:0] ADDR_GROUP_APPLY = 14'h0055;

    // ------------------------------------------------------------
    // Page codes
    // ------------------------------------------------------------
    localparam logic [7:0]  PAGE_MASTER    = 8'h80;
    localparam logic [7:0]  PAGE_CONVERTER = 8'h0F;

    // ------------------------------------------------------------
    // Reset values and writable-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0]  RESET_VALUE    = 8'h00;
    localparam logic [7:0]  CONV_MASK      = 8'hFF;
    localparam logic [7:0]  BUF_MASK       = 8'hF0;
    localparam logic [7:0]  CTRL_MASK      = 8'hE0;
    localparam logic [7:0]  APPLY_MASK     = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          SLEEP_REQ_BIT   = 7;
    localparam int          IGNORE_PIN_BIT  = 6;
    localparam int          GROUP_SEL_BIT   = 5;
    localparam int          GROUP_APPLY_BIT = 4;
    localparam int          SWRST_HI_BIT    = 7;
    localparam int          SWRST_LO_BIT    = 0;

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PSM_IDLE  = 2'h0,
        PSM_SHIFT = 2'h1,
        PSM_DONE  = 2'h3
    } psm_state_type;

endpackage : psm_pkg

// ### psm_sync.sv
// Two-flip-flop synchroniser for one pin
`timescale 1ns/10ps
`default_nettype none

module psm_sync
#(
    parameter logic INIT = 1'b0
)
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic pin_in,
    output var  logic pin_out
);

    logic stage1_reg;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stage1_reg <= INIT;
            pin_out    <= INIT;
        end
        else
        begin
            stage1_reg <= pin_in;
            pin_out    <= stage1_reg;
        end
    end

endmodule : psm_sync

`default_nettype wire

// ### tb_psm_page_sleep.sv
// Testbench: page select, sleep masks and chip sleep
`timescale 1ns/10ps
`default_nettype none

module tb_psm_page_sleep;
    logic       clk, sys_rst, sleep_pin, sel_n, sclk, sdin, sdout, sdout_oe;
    logic       chip_sleep, conv_page;
    logic [3:0] conv_ab, conv_cd;
    logic [1:0] buf_ab, buf_cd;
    logic [7:0] q;
    int         n_fail, n_tests, cyc;

    psm_page_sleep u_dut (.clk(clk), .sys_rst(sys_rst), .cfg_sel_n(sel_n),
        .cfg_sclk(sclk), .cfg_sdin(sdin), .sleep_pin(sleep_pin), .cfg_sdout(sdout),
        .cfg_sdout_oe(sdout_oe), .converter_sleep_first_pair(conv_ab),
        .converter_sleep_second_pair(conv_cd), .input_buffer_sleep_first_pair(buf_ab),
        .input_buffer_sleep_second_pair(buf_cd), .chip_sleep(chip_sleep),
        .converter_page_selected(conv_page));
    psm_host u_host (.clk(clk), .cfg_sdout(sdout), .cfg_sel_n(sel_n), .cfg_sclk(sclk),
        .cfg_sdin(sdin));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_fail++;
            results();
        end
    end

    task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        u_host.xfer({2'b00, a, d}, q);
    endtask : wr

    task automatic rd(input logic [13:0] a, input logic [7:0] e);
        u_host.xfer({2'b10, a, 8'h00}, q);
        chk("register", {4'h0, q}, {4'h0, e});
        chk("read driver", {11'h000, sdout_oe}, 12'h000);
    endtask : rd

    task automatic outs(input logic [11:0] e);
        chk("mask outputs", {conv_ab, conv_cd, buf_cd, buf_ab}, e);
    endtask : outs

    task automatic t_reset();
        logic [13:0] regs [5];
        regs = '{14'h0020, 14'h0021, 14'h0023, 14'h0024, 14'h0026};
        outs(12'h000);
        rd(psm_pkg::ADDR_PAGE_SELECT, 8'h00);
        wr(psm_pkg::ADDR_PAGE_SELECT, psm_pkg::PAGE_MASTER);
        foreach (regs[i]) rd(regs[i], 8'h00);
        rd(psm_pkg::ADDR_GROUP_APPLY, 8'h00);
    endtask : t_reset

    task automatic t_page();
        wr(psm_pkg::ADDR_PAGE_SELECT, psm_pkg::PAGE_CONVERTER);
        chk("page flag", {11'h000, conv_page}, 12'h001);
        wr(psm_pkg::ADDR_M1_CONV, 8'hA5);
        wr(psm_pkg::ADDR_PAGE_SELECT, 8'h00);
        chk("page flag", {11'h000, conv_page}, 12'h000);
        wr(psm_pkg::ADDR_PAGE_SELECT, psm_pkg::PAGE_MASTER);
        rd(psm_pkg::ADDR_PAGE_SELECT, 8'h80);
        rd(psm_pkg::ADDR_M1_CONV, 8'h00);
        u_host.xfer({2'b01, psm_pkg::ADDR_M1_CONV, 8'hFF}, q);
        rd(psm_pkg::ADDR_M1_CONV, 8'h00);
        rd(14'h0012, 8'h00);
    endtask : t_page

    task automatic t_masks();
        wr(psm_pkg::ADDR_M1_CONV, 8'h5C);
        wr(psm_pkg::ADDR_M1_BUF, 8'h60);
        wr(psm_pkg::ADDR_M2_CONV, 8'h3E);
        wr(psm_pkg::ADDR_M2_BUF, 8'h90);
        rd(psm_pkg::ADDR_M1_CONV, 8'h5C);
        rd(psm_pkg::ADDR_M1_BUF, 8'h60);
        rd(psm_pkg::ADDR_M2_CONV, 8'h3E);
        rd(psm_pkg::ADDR_M2_BUF, 8'h90);
        outs(12'h000);
        wr(psm_pkg::ADDR_GROUP_APPLY, 8'h10);
        outs(12'h5C6);
        wr(psm_pkg::ADDR_GLOBAL_CTRL, 8'h20);
        outs(12'h3E9);
        rd(psm_pkg::ADDR_GLOBAL_CTRL, 8'h20);
        wr(psm_pkg::ADDR_GROUP_APPLY, 8'h00);
        outs(12'h000);
        wr(psm_pkg::ADDR_GLOBAL_CTRL, 8'h00);
    endtask : t_masks

    task automatic t_sleep();
        @(posedge clk) sleep_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("chip sleep", {11'h000, chip_sleep}, 12'h001);
        wr(psm_pkg::ADDR_GLOBAL_CTRL, 8'hC0);
        rd(psm_pkg::ADDR_GLOBAL_CTRL, 8'h40);
        chk("chip sleep", {11'h000, chip_sleep}, 12'h000);
        wr(psm_pkg::ADDR_GLOBAL_CTRL, 8'hC0);
        rd(psm_pkg::ADDR_GLOBAL_CTRL, 8'hC0);
        @(posedge clk) sleep_pin <= 1'b0;
        repeat (8) @(posedge clk);
        chk("chip sleep", {11'h000, chip_sleep}, 12'h001);
        wr(psm_pkg::ADDR_GLOBAL_CTRL, 8'h00);
        chk("chip sleep", {11'h000, chip_sleep}, 12'h000);
    endtask : t_sleep

    task automatic t_soft();
        wr(psm_pkg::ADDR_GROUP_APPLY, 8'h10);
        wr(psm_pkg::ADDR_SOFT_RESET, 8'h80);
        outs(12'h5C6);
        wr(psm_pkg::ADDR_SOFT_RESET, 8'h81);
        outs(12'h000);
        rd(psm_pkg::ADDR_PAGE_SELECT, 8'h00);
        wr(psm_pkg::ADDR_PAGE_SELECT, psm_pkg::PAGE_MASTER);
        rd(psm_pkg::ADDR_GROUP_APPLY, 8'h00);
        rd(psm_pkg::ADDR_M1_CONV, 8'h00);
    endtask : t_soft

    initial
    begin
        sys_rst = 1'b1;
        sleep_pin = 1'b0;
        n_fail = 0;
        n_tests = 0;
        cyc = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset();
        t_page();
        t_masks();
        t_sleep();
        t_soft();
        results();
    end
endmodule : tb_psm_page_sleep

`default_nettype wire
